// file: rtl/clk_monitor.v
// Serial clock edge finder and glitch detector on a synchronised clock level
`default_nettype none

module clk_monitor #(
  parameter MIN_CYC = 2
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Monitored level and detector enable
  input wire level,
  input wire enable,
  // One-cycle pulses
  output reg rise,
  output reg glitch
);

  reg prev_reg;
  reg [3:0] run_reg;

  // Run length of the current level; a too-short run is a glitch
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prev_reg <= 1'b0;
      run_reg <= 4'hF;
      rise <= 1'b0;
      glitch <= 1'b0;
    end
    else
    begin
      prev_reg <= level;
      rise <= level & ~prev_reg;
      glitch <= 1'b0;
      if (level != prev_reg)
      begin
        run_reg <= 4'h1;
        glitch <= enable & (run_reg < MIN_CYC[3:0]);
      end
      else if (run_reg != 4'hF)
        run_reg <= run_reg + 4'h1; // Saturate: only short runs matter
    end
  end

endmodule

`default_nettype wire

// file: rtl/pin_sync.v
// Two-flop synchroniser for pins from outside the system clock domain
`default_nettype none

module pin_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Raw and synchronised levels
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pin_out
);

  reg [W-1:0] meta_reg;

  // First stage is read by the second stage only
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_reg <= {W{1'b0}};
      pin_out <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= pin_in;
      pin_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: rtl/serial_channel_defs.vh
// Register map, field positions, reset values and timing counts of the serial channel mode block
`ifndef SERIAL_CHANNEL_DEFS_VH
`define SERIAL_CHANNEL_DEFS_VH

// Word indexes on the AHB-Lite bus (byte address = 4 * index)
`define GM_LOW_IDX 2'h0
`define GM_HIGH_IDX 2'h1
`define EVENT_IDX 2'h2
`define STATUS_IDX 2'h3

// Reset values
`define GM_LOW_RESET 31'h00000000
`define GM_HIGH_RESET 17'h00000
`define EVENT_RESET 5'h00

// High-word field positions, counted from bit 32
`define F_GDE 16
`define F_TRANSPARENT_CHECK_SELECT_HI 15
`define F_TRANSPARENT_CHECK_SELECT_LO 14
`define F_REVERSE_BIT_ORDER 13
`define F_TRX 12
`define F_TTX 11
`define F_CDP 10
`define F_CLEAR_TO_SEND_PULSE_MODE 9
`define F_CDS 8
`define F_CLEAR_TO_SEND_SAMPLING_SYNC 7
`define F_TFL 6
`define F_RFW 5
`define F_TX_SYNC_TO_RX 4
`define F_RX_SYNC_TIMING 0

// Event register bits
`define EV_GLITCH_RX 0
`define EV_GLITCH_TX 1
`define EV_CD_LOST 2
`define EV_CTS_LOST 3
`define EV_CHECK_ERR 4

// Frame-check encodings
`define CHECK_RESERVED 2'h3

// FIFO geometry in bytes
`define TX_DEPTH_FIRST 6'h20
`define TX_DEPTH_OTHER 6'h10
`define DEPTH_ONE 6'h01
`define RX_NARROW_FIRST 6'h08
`define RX_NARROW_OTHER 6'h04
`define RX_WRITE_WIDE 3'h4
`define RX_WRITE_NARROW 3'h1

// Serial clock edge counts
`define CD_SYNC_EDGES 2'h1
`define CD_ASYNC_EDGES 2'h2
`define TX_ALIGN_EDGES 4'h8
`define CTS_SYNC_EDGES 4'h1

// Glitch limit: shortest legal clock half-period
`define SYS_CLK_MHZ 20
`define GLITCH_MIN_NS 80
`define GLITCH_MIN_CYC ((`GLITCH_MIN_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/serial_channel_general_mode.v
// General mode register bank of one serial channel with modem-line and clock supervision
`default_nettype none
`include "serial_channel_defs.vh"
// Contract
// R1 - 64-bit mode register reached as low word and high word
// R2 - Mode register is read-write and cleared to zero at reset
// R3 - Glitch enable turns on serial clock glitch detection, reported as event
// R4 - Software keeps glitch detection off for fast or internal clocks
// R5 - Check field picks CCITT-16, CRC16 or CCITT-32; 11 reserved
// R6 - Transparent transmit appends check only on descriptor request; errors still reported
// R7 - Reverse bit sends MSB first on transparent halves
// R8 - Transparent receiver bit overrides protocol mode for receiver
// R9 - Transparent transmitter bit overrides protocol mode for transmitter
// R10 - Software keeps both transparent bits equal in Ethernet mode
// R11 - Carrier envelope mode flags carrier loss; pulse mode ignores later transitions
// R12 - Software sets carrier pulse mode when routed through time slot assigner
// R13 - Clear-to-send envelope mode flags loss; pulse mode ignores later transitions
// R14 - Async carrier is synchronised first; sync carrier starts reception at once
// R15 - Remote changes synchronous carrier only while receive clock is low
// R16 - Async clear-to-send delays start several clocks; sync starts immediately
// R17 - Remote changes synchronous clear-to-send only while transmit clock is low
// R18 - Transmit FIFO depth 32 or 16 bytes, or one byte when set
// R19 - Wide receive FIFO is 32 bits; writes wait for 32 bits
// R20 - Narrow receive FIFO is 8 bits, quarter depth, writes each character
// R21 - Software picks narrow FIFO for character protocols, wide for frames
// R22 - Transmit aligns to receiver; with sync timing waits, then eight clocks
// R23 - Sync timing with sync carrier expects carrier on second bit
// R24 - Reserved bits read zero and ignore writes

module serial_channel_general_mode #(
  parameter FIRST_CHANNEL = 1,
  parameter CTS_ASYNC_EDGES = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Serial clock and modem pins
  input wire rx_clk,
  input wire tx_clk,
  input wire cd_n,
  input wire cts_n,
  // Protocol engine handshake
  input wire rx_enable,
  input wire tx_request,
  input wire bd_check_request,
  input wire rx_check_error,
  // Configuration to the engines
  output reg rx_transparent,
  output reg tx_transparent,
  output reg [1:0] check_select,
  output reg check_select_valid,
  output reg rx_reverse,
  output reg tx_reverse,
  output reg tx_append_check,
  output reg [5:0] tx_fifo_depth,
  output reg rx_fifo_narrow,
  output reg [5:0] rx_fifo_depth,
  output reg [2:0] rx_write_bytes,
  output reg tx_align_to_rx,
  output reg rx_cd_second_bit,
  output reg [30:0] low_config,
  // Line state
  output reg rx_receiving,
  output reg tx_sending
);

  localparam RX_IDLE = 3'b001;
  localparam RX_WAIT = 3'b010;
  localparam RX_RUN = 3'b100;
  localparam TX_IDLE = 3'b001;
  localparam TX_WAIT = 3'b010;
  localparam TX_RUN = 3'b100;

  reg [30:0] low_reg;
  reg [16:0] high_reg;
  reg [4:0] event_reg;
  reg [4:0] event_next;
  reg [2:0] rx_reg;
  reg [2:0] rx_next;
  reg [1:0] rx_cnt_reg;
  reg [1:0] rx_cnt_next;
  reg [2:0] tx_reg;
  reg [2:0] tx_next;
  reg [3:0] tx_cnt_reg;
  reg [3:0] tx_cnt_next;
  reg cd_lost;
  reg cts_lost;
  reg ap_write_reg;
  reg ap_read_reg;
  reg ap_hit_reg;
  reg [1:0] ap_idx_reg;
  reg [31:0] rd_mux;
  reg [31:0] w1c;
  wire [3:0] pins_s;
  wire rx_rise;
  wire tx_rise;
  wire rx_glitch;
  wire tx_glitch;
  wire take;
  wire cd_on;
  wire cts_on;
  wire glitch_detect_enable;
  wire transparent_receiver;
  wire transparent_transmitter;
  wire carrier_pulse_mode;
  wire clear_to_send_pulse_mode;
  wire carrier_sampling_sync;
  wire clear_to_send_sampling_sync;
  wire rx_sync_timing;
  wire tx_wait_rx;
  wire [1:0] rx_target;
  wire [3:0] tx_target;

  // All four pins come from outside the clock domain
  pin_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({cts_n, cd_n, tx_clk, rx_clk}),
    .pin_out(pins_s)
  );

  // Serial clock supervision, detector idle while glitch detection is off
  clk_monitor #(
    .MIN_CYC(`GLITCH_MIN_CYC)
  ) u_rx_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .level(pins_s[0]),
    .enable(glitch_detect_enable), // [R3]
    .rise(rx_rise),
    .glitch(rx_glitch)
  );

  clk_monitor #(
    .MIN_CYC(`GLITCH_MIN_CYC)
  ) u_tx_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .level(pins_s[1]),
    .enable(glitch_detect_enable), // [R3]
    .rise(tx_rise),
    .glitch(tx_glitch)
  );

  // Field taps of the high word, and modem lines decoded from active-low pins
  assign glitch_detect_enable = high_reg[`F_GDE];
  assign transparent_receiver = high_reg[`F_TRX];
  assign transparent_transmitter = high_reg[`F_TTX];
  assign carrier_pulse_mode = high_reg[`F_CDP];
  assign clear_to_send_pulse_mode = high_reg[`F_CLEAR_TO_SEND_PULSE_MODE];
  assign carrier_sampling_sync = high_reg[`F_CDS];
  assign clear_to_send_sampling_sync = high_reg[`F_CLEAR_TO_SEND_SAMPLING_SYNC];
  assign rx_sync_timing = high_reg[`F_RX_SYNC_TIMING];
  assign cd_on = ~pins_s[2];
  assign cts_on = ~pins_s[3];

  // Bus address phase accepted
  assign take = hsel & hready & htrans[1];

  // Read multiplexer; unmapped words and reserved bits read zero
  always @*
  begin
    rd_mux = 32'h00000000;
    if (ap_hit_reg)
    begin
      case (ap_idx_reg)
        `GM_LOW_IDX: rd_mux = {1'b0, low_reg}; // [R1] [R24]
        `GM_HIGH_IDX: rd_mux = {15'h0000, high_reg}; // [R1] [R24]
        `EVENT_IDX: rd_mux = {27'h0000000, event_reg};
        `STATUS_IDX: rd_mux = {24'h000000, tx_reg, rx_reg, cts_on, cd_on};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Bus slave: writes take no wait state, reads one so data follows any write
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ap_write_reg <= 1'b0;
      ap_read_reg <= 1'b0;
      ap_hit_reg <= 1'b0;
      ap_idx_reg <= 2'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else if (ap_read_reg)
    begin
      hrdata <= rd_mux;
      hreadyout <= 1'b1;
      ap_read_reg <= 1'b0;
    end
    else
    begin
      ap_write_reg <= take & hwrite;
      ap_read_reg <= take & ~hwrite;
      hreadyout <= ~(take & ~hwrite);
      if (take)
      begin
        ap_hit_reg <= (haddr[31:4] == 28'h0000000) & (haddr[1:0] == 2'h0);
        ap_idx_reg <= haddr[3:2];
      end
    end
  end

  // Mode register words; reserved bits are simply not stored
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      low_reg <= `GM_LOW_RESET; // [R2]
      high_reg <= `GM_HIGH_RESET; // [R2]
    end
    else if (ap_write_reg & ap_hit_reg)
    begin
      if (ap_idx_reg == `GM_LOW_IDX)
        low_reg <= hwdata[30:0]; // [R1] [R2] [R24]
      if (ap_idx_reg == `GM_HIGH_IDX)
        high_reg <= hwdata[16:0]; // [R1] [R2] [R24]
    end
  end

  // Sticky events: write one to clear, a new event wins over the clear
  always @*
  begin
    w1c = 32'h00000000;
    if (ap_write_reg & ap_hit_reg & (ap_idx_reg == `EVENT_IDX))
      w1c = hwdata;
    event_next = event_reg & ~w1c[4:0];
    if (rx_glitch)
      event_next[`EV_GLITCH_RX] = 1'b1; // [R3]
    if (tx_glitch)
      event_next[`EV_GLITCH_TX] = 1'b1; // [R3]
    if (cd_lost)
      event_next[`EV_CD_LOST] = 1'b1; // [R11]
    if (cts_lost)
      event_next[`EV_CTS_LOST] = 1'b1; // [R13]
    if (rx_check_error)
      event_next[`EV_CHECK_ERR] = 1'b1; // [R6]
  end

  // Receiver start needs one rx clock edge with sync carrier, more otherwise
  assign rx_target = carrier_sampling_sync ? `CD_SYNC_EDGES : `CD_ASYNC_EDGES; // [R14]

  // Receiver carrier state machine
  always @*
  begin
    rx_next = rx_reg;
    rx_cnt_next = rx_cnt_reg;
    cd_lost = 1'b0;
    case (rx_reg)
      RX_IDLE:
      begin
        rx_cnt_next = 2'h0;
        if (rx_enable & cd_on)
          rx_next = RX_WAIT;
      end
      RX_WAIT:
      begin
        if (~rx_enable | (~cd_on & ~carrier_pulse_mode))
          rx_next = RX_IDLE;
        else if (rx_rise)
        begin
          rx_cnt_next = rx_cnt_reg + 2'h1;
          if (rx_cnt_reg + 2'h1 == rx_target)
            rx_next = RX_RUN; // [R14]
        end
      end
      RX_RUN:
      begin
        if (~rx_enable)
          rx_next = RX_IDLE;
        else if (~cd_on & ~carrier_pulse_mode)
        begin
          cd_lost = 1'b1; // [R11]
          rx_next = RX_IDLE;
        end
      end
      default:
        rx_next = RX_IDLE;
    endcase
  end

  // Transparent transmit with sync timing waits for the receiver first
  assign tx_wait_rx = high_reg[`F_TX_SYNC_TO_RX] & rx_sync_timing & transparent_transmitter; // [R22]
  assign tx_target = tx_wait_rx ? `TX_ALIGN_EDGES :
    (clear_to_send_sampling_sync ? `CTS_SYNC_EDGES : CTS_ASYNC_EDGES[3:0]); // [R16] [R22]

  // Transmitter clear-to-send state machine
  always @*
  begin
    tx_next = tx_reg;
    tx_cnt_next = tx_cnt_reg;
    cts_lost = 1'b0;
    case (tx_reg)
      TX_IDLE:
      begin
        tx_cnt_next = 4'h0;
        if (tx_request & cts_on & (~tx_wait_rx | (rx_reg == RX_RUN)))
          tx_next = TX_WAIT; // [R22]
      end
      TX_WAIT:
      begin
        if (~tx_request | (~cts_on & ~clear_to_send_pulse_mode))
          tx_next = TX_IDLE;
        else if (tx_rise)
        begin
          tx_cnt_next = tx_cnt_reg + 4'h1;
          if (tx_cnt_reg + 4'h1 == tx_target)
            tx_next = TX_RUN; // [R16] [R22]
        end
      end
      TX_RUN:
      begin
        if (~tx_request)
          tx_next = TX_IDLE;
        else if (~cts_on & ~clear_to_send_pulse_mode)
        begin
          cts_lost = 1'b1; // [R13]
          tx_next = TX_IDLE;
        end
      end
      default:
        tx_next = TX_IDLE;
    endcase
  end

  // State, events and line-state outputs
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_reg <= RX_IDLE;
      rx_cnt_reg <= 2'h0;
      tx_reg <= TX_IDLE;
      tx_cnt_reg <= 4'h0;
      event_reg <= `EVENT_RESET;
      rx_receiving <= 1'b0;
      tx_sending <= 1'b0;
    end
    else
    begin
      rx_reg <= rx_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_reg <= tx_next;
      tx_cnt_reg <= tx_cnt_next;
      event_reg <= event_next;
      rx_receiving <= (rx_next == RX_RUN);
      tx_sending <= (tx_next == TX_RUN);
    end
  end

  // Decoded configuration, registered so every output leaves a flop
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_transparent <= 1'b0;
      tx_transparent <= 1'b0;
      check_select <= 2'h0;
      check_select_valid <= 1'b1;
      rx_reverse <= 1'b0;
      tx_reverse <= 1'b0;
      tx_append_check <= 1'b0;
      tx_fifo_depth <= `TX_DEPTH_OTHER;
      rx_fifo_narrow <= 1'b0;
      rx_fifo_depth <= `TX_DEPTH_OTHER;
      rx_write_bytes <= `RX_WRITE_WIDE;
      tx_align_to_rx <= 1'b0;
      rx_cd_second_bit <= 1'b0;
      low_config <= `GM_LOW_RESET;
    end
    else
    begin
      rx_transparent <= transparent_receiver; // [R8]
      tx_transparent <= transparent_transmitter; // [R9]
      check_select <= high_reg[`F_TRANSPARENT_CHECK_SELECT_HI:`F_TRANSPARENT_CHECK_SELECT_LO]; // [R5]
      check_select_valid <= high_reg[`F_TRANSPARENT_CHECK_SELECT_HI:`F_TRANSPARENT_CHECK_SELECT_LO] != `CHECK_RESERVED; // [R5]
      rx_reverse <= high_reg[`F_REVERSE_BIT_ORDER] & transparent_receiver; // [R7]
      tx_reverse <= high_reg[`F_REVERSE_BIT_ORDER] & transparent_transmitter; // [R7]
      // Check word goes out only when the descriptor asks for it
      tx_append_check <= transparent_transmitter & bd_check_request; // [R6]
      if (high_reg[`F_TFL])
        tx_fifo_depth <= `DEPTH_ONE; // [R18]
      else
        tx_fifo_depth <= (FIRST_CHANNEL != 0) ? `TX_DEPTH_FIRST : `TX_DEPTH_OTHER; // [R18]
      rx_fifo_narrow <= high_reg[`F_RFW]; // [R19] [R20]
      if (high_reg[`F_RFW])
      begin
        rx_fifo_depth <= (FIRST_CHANNEL != 0) ? `RX_NARROW_FIRST : `RX_NARROW_OTHER; // [R20]
        rx_write_bytes <= `RX_WRITE_NARROW; // [R20]
      end
      else
      begin
        rx_fifo_depth <= (FIRST_CHANNEL != 0) ? `TX_DEPTH_FIRST : `TX_DEPTH_OTHER; // [R19]
        rx_write_bytes <= `RX_WRITE_WIDE; // [R19]
      end
      tx_align_to_rx <= high_reg[`F_TX_SYNC_TO_RX]; // [R22]
      rx_cd_second_bit <= rx_sync_timing & carrier_sampling_sync & transparent_receiver; // [R23]
      low_config <= low_reg;
    end
  end

endmodule

`default_nettype wire

// file: verification/serial_channel_general_mode_checker.sv
// Assertion checker for the serial channel general mode block
`default_nettype none
module serial_channel_general_mode_checker #(
  parameter FIRST_CHANNEL = 1
) (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Engine handshake
  input wire logic rx_enable,
  input wire logic tx_request,
  input wire logic bd_check_request,
  // Configuration and line state
  input wire logic rx_transparent,
  input wire logic tx_transparent,
  input wire logic [1:0] check_select,
  input wire logic check_select_valid,
  input wire logic rx_reverse,
  input wire logic tx_reverse,
  input wire logic tx_append_check,
  input wire logic rx_fifo_narrow,
  input wire logic [5:0] rx_fifo_depth,
  input wire logic [2:0] rx_write_bytes,
  input wire logic rx_cd_second_bit,
  input wire logic rx_receiving,
  input wire logic tx_sending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus answers: one wait state per read, always OKAY
  chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  // Decoded configuration against its own fields
  chk_check_valid: assert property (check_select_valid == (check_select != 2'h3))
    else $error("check valid flag wrong");
  chk_reverse_half: assert property (!(rx_reverse && !rx_transparent) && !(tx_reverse && !tx_transparent))
    else $error("reverse on non transparent half");
  chk_append_cause: assert property (tx_append_check |-> $past(bd_check_request) && tx_transparent)
    else $error("check appended without request");
  chk_narrow_depth: assert property (!$past(rst) && rx_fifo_narrow
    |-> rx_fifo_depth == (FIRST_CHANNEL != 0 ? 6'h08 : 6'h04) && rx_write_bytes == 3'h1)
    else $error("narrow fifo geometry wrong");
  chk_wide_depth: assert property (!$past(rst) && !rx_fifo_narrow
    |-> rx_fifo_depth == (FIRST_CHANNEL != 0 ? 6'h20 : 6'h10) && rx_write_bytes == 3'h4)
    else $error("wide fifo geometry wrong");
  chk_second_bit: assert property (rx_cd_second_bit |-> rx_transparent)
    else $error("second bit timing off transparent");
  // Line state only starts when requested
  chk_rx_start: assert property ($rose(rx_receiving) |-> $past(rx_enable))
    else $error("reception without enable");
  chk_tx_start: assert property ($rose(tx_sending) |-> $past(tx_request))
    else $error("transmission without request");
  cov_rx_run: cover property ($rose(rx_receiving));
  cov_rx_lost: cover property ($fell(rx_receiving) && rx_enable);
  cov_tx_run: cover property ($rose(tx_sending));
endmodule
bind serial_channel_general_mode serial_channel_general_mode_checker #(.FIRST_CHANNEL(FIRST_CHANNEL)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .rx_enable(rx_enable), .tx_request(tx_request),
  .bd_check_request(bd_check_request), .rx_transparent(rx_transparent), .tx_transparent(tx_transparent),
  .check_select(check_select), .check_select_valid(check_select_valid), .rx_reverse(rx_reverse),
  .tx_reverse(tx_reverse), .tx_append_check(tx_append_check), .rx_fifo_narrow(rx_fifo_narrow),
  .rx_fifo_depth(rx_fifo_depth), .rx_write_bytes(rx_write_bytes), .rx_cd_second_bit(rx_cd_second_bit),
  .rx_receiving(rx_receiving), .tx_sending(tx_sending));
`default_nettype wire

// file: verification/serial_channel_general_mode_tb.sv
// Self-checking bench for the serial channel general mode block
`default_nettype none
module serial_channel_general_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans, check_select;
  logic [2:0] hsize, rx_write_bytes;
  logic [31:0] haddr, hwdata, hrdata;
  logic rx_clk, tx_clk, cd_n, cts_n, rx_enable, tx_request, bd_check_request, rx_check_error;
  logic rx_transparent, tx_transparent, check_select_valid, rx_reverse, tx_reverse, tx_append_check;
  logic rx_fifo_narrow, tx_align_to_rx, rx_cd_second_bit, rx_receiving, tx_sending;
  logic [5:0] tx_fifo_depth, rx_fifo_depth;
  logic [30:0] low_config;
  logic rx_run, tx_run, cd_on, cts_on, glitch_req;
  int err_total, n_checks;
  assign hready = hreadyout;
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = !ref_clk;
  end
  serial_channel_general_mode #(.FIRST_CHANNEL(1), .CTS_ASYNC_EDGES(3)) i_serial_channel_general_mode (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_clk(rx_clk), .tx_clk(tx_clk), .cd_n(cd_n), .cts_n(cts_n),
    .rx_enable(rx_enable), .tx_request(tx_request), .bd_check_request(bd_check_request),
    .rx_check_error(rx_check_error), .rx_transparent(rx_transparent), .tx_transparent(tx_transparent),
    .check_select(check_select), .check_select_valid(check_select_valid), .rx_reverse(rx_reverse),
    .tx_reverse(tx_reverse), .tx_append_check(tx_append_check), .tx_fifo_depth(tx_fifo_depth),
    .rx_fifo_narrow(rx_fifo_narrow), .rx_fifo_depth(rx_fifo_depth), .rx_write_bytes(rx_write_bytes),
    .tx_align_to_rx(tx_align_to_rx), .rx_cd_second_bit(rx_cd_second_bit), .low_config(low_config),
    .rx_receiving(rx_receiving), .tx_sending(tx_sending));
  serial_line_model i_serial_line_model (.rx_run(rx_run), .tx_run(tx_run), .cd_on(cd_on),
    .cts_on(cts_on), .glitch_req(glitch_req), .rx_clk(rx_clk), .tx_clk(tx_clk), .cd_n(cd_n), .cts_n(cts_n));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      complete_run();
    end
  endtask
  // One single AHB-Lite word transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(nm, e, q);
  endtask
  // Bounded wait for a line state level
  task automatic wait_line(input bit tx, input logic v);
    int n;
    n = 0;
    while ((tx ? tx_sending : rx_receiving) !== v && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("line state", {31'h0, v}, {31'h0, tx ? tx_sending : rx_receiving});
    if (n >= 400)
      complete_run();
  endtask
  task automatic glitch();
    glitch_req <= 1'b1;
    @(posedge ref_clk);
    glitch_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  initial
  begin
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {2'b11, 67'h0};
    {rx_enable, tx_request, bd_check_request, rx_check_error} = 4'h0;
    {rx_run, tx_run, cd_on, cts_on, glitch_req} = 5'h00;
    hsize = 3'h2;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // Registers: reset value, reserved bits, decoded fields
    rd("low", 32'h0, 32'h0);
    rd("high", 32'h4, 32'h0);
    wr(32'h0, 32'hFFFFFFFF);
    rd("low", 32'h0, 32'h7FFFFFFF);
    wr(32'h4, 32'hFFFFFFFF);
    rd("high", 32'h4, 32'h0001FFFF);
    chk("low_config", 32'h7FFFFFFF, {1'b0, low_config});
    chk("tx_depth", 32'h1, {26'h0, tx_fifo_depth});
    chk("rx_depth", 32'h8, {26'h0, rx_fifo_depth});
    chk("align", 32'h1, {31'h0, tx_align_to_rx});
    chk("second_bit", 32'h1, {31'h0, rx_cd_second_bit});
    wr(32'h10, 32'hFFFFFFFF);
    rd("unmapped", 32'h10, 32'h0);
    wr(32'h4, 32'h0);
    rd("high", 32'h4, 32'h0);
    chk("tx_depth", 32'h20, {26'h0, tx_fifo_depth});
    chk("rx_bytes", 32'h4, {29'h0, rx_write_bytes});
    $display("test registers done");
    // Every check code, alternating transparent half, reverse on
    bd_check_request <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(32'h4, (c << 14) | 32'h2000 | (c[0] ? 32'h800 : 32'h1000));
      repeat (3) @(posedge ref_clk);
      chk("check_select", c, {30'h0, check_select});
      chk("check_valid", (c != 3), {31'h0, check_select_valid});
      chk("reverse", {c[0], !c[0]}, {tx_reverse, rx_reverse});
      chk("transparent", {c[0], !c[0]}, {tx_transparent, rx_transparent});
      chk("append", c[0], {31'h0, tx_append_check});
    end
    bd_check_request <= 1'b0;
    wr(32'h4, 32'h0);
    $display("test fields done");
    // Reception: async carrier, envelope loss, then pulse mode
    rx_enable <= 1'b1;
    cd_on <= 1'b1;
    rx_run <= 1'b1;
    wait_line(1'b0, 1'b1);
    cd_on <= 1'b0;
    wait_line(1'b0, 1'b0);
    rd("event", 32'h8, 32'h4);
    wr(32'h8, 32'h4);
    rd("event", 32'h8, 32'h0);
    // Pulse mode with synchronous carrier, as a channel behind the slot assigner
    wr(32'h4, 32'h500);
    cd_on <= 1'b1;
    wait_line(1'b0, 1'b1);
    cd_on <= 1'b0;
    repeat (60) @(posedge ref_clk);
    chk("pulse hold", 32'h1, {31'h0, rx_receiving});
    rd("status", 32'hC, 32'h30);
    rx_enable <= 1'b0;
    wait_line(1'b0, 1'b0);
    rx_run <= 1'b0;
    $display("test receive done");
    // Transmission: sync clear-to-send, envelope loss
    wr(32'h4, 32'h80);
    tx_request <= 1'b1;
    cts_on <= 1'b1;
    tx_run <= 1'b1;
    wait_line(1'b1, 1'b1);
    cts_on <= 1'b0;
    wait_line(1'b1, 1'b0);
    rd("event", 32'h8, 32'h8);
    wr(32'h8, 32'h8);
    // Transparent transmit tied to the receiver: waits for it, then eight clocks
    wr(32'h4, 32'h811);
    {rx_enable, tx_request, cd_on, cts_on, rx_run, tx_run} <= 6'h3F;
    wait_line(1'b1, 1'b1);
    chk("rx first", 32'h1, {31'h0, rx_receiving});
    {rx_enable, tx_request, cd_on, cts_on, rx_run, tx_run} <= 6'h00;
    $display("test transmit done");
    // Check error report and clock glitch with detection off then on
    rx_check_error <= 1'b1;
    @(posedge ref_clk);
    rx_check_error <= 1'b0;
    rd("event", 32'h8, 32'h10);
    wr(32'h8, 32'h10);
    wr(32'h4, 32'h0);
    glitch();
    rd("event", 32'h8, 32'h0);
    wr(32'h4, 32'h10000);
    glitch();
    rd("event", 32'h8, 32'h1);
    $display("test events done");
    complete_run();
  end
endmodule
`default_nettype wire

// file: verification/serial_line_model.sv
// Serial line model: framed serial clocks, carrier and clear-to-send pins
`default_nettype none
module serial_line_model #(
  parameter int HALF_NS = 200
) (
  // Frame control
  input wire logic rx_run,
  input wire logic tx_run,
  input wire logic cd_on,
  input wire logic cts_on,
  input wire logic glitch_req,
  // Line pins
  output var logic rx_clk,
  output var logic tx_clk,
  output var logic cd_n,
  output var logic cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    rx_clk = 1'b0;
    tx_clk = 1'b0;
    cd_n = 1'b1;
    cts_n = 1'b1;
  end
  // Clocks run only in frames and always stop low
  always
  begin
    wait (rx_run);
    #HALF_NS rx_clk = 1'b1;
    #HALF_NS rx_clk = 1'b0;
  end
  always
  begin
    wait (tx_run);
    #HALF_NS tx_clk = 1'b1;
    #HALF_NS tx_clk = 1'b0;
  end
  // Pins only move while their clock is low, so sync sampling is safe
  always @*
  begin
    if (!rx_clk)
      cd_n = !cd_on;
    if (!tx_clk)
      cts_n = !cts_on;
  end
  // Commanded fault: a pulse much shorter than a legal half-period
  always @(posedge glitch_req)
  begin
    #5 rx_clk = 1'b1;
    #60 rx_clk = 1'b0;
  end
endmodule
`default_nettype wire
